// ---- hdl/dic_pkg.sv ----
// digital input conditioner: sizes, register map, reset values, function codes
// assumes a 250 MHz system clock and an APB register port
package dic_pkg;
  // ==========================================
  // sizes
  localparam int NUM_IN = 8;
  localparam int NUM_CONTACT = 4;
  localparam int FUNC_W = 16;
  localparam int DLY_W = 16;
  localparam int MSG_W = 8;
  localparam int ADDR_W = 12;
  // ==========================================
  // timing
  localparam int CLK_PERIOD_NS = 4;
  localparam int DELAY_UNIT_MS = 1;
  localparam int TICK_CYCLES = (DELAY_UNIT_MS * 1000000) / CLK_PERIOD_NS;
  // ==========================================
  // register map, byte addresses
  localparam logic [ADDR_W-1:0] OFS_POL_CONTACT = 12'h000;
  localparam logic [ADDR_W-1:0] OFS_POL_AUX = 12'h004;
  localparam logic [ADDR_W-1:0] OFS_FUNC_BASE = 12'h020;
  localparam logic [ADDR_W-1:0] OFS_DLY_BASE = 12'h040;
  localparam logic [ADDR_W-1:0] OFS_MSG_BASE = 12'h060;
  localparam logic [ADDR_W-1:0] OFS_STATE = 12'h080;
  localparam logic [ADDR_W-1:0] OFS_QUAL = 12'h084;
  localparam int OFS_STRIDE = 4;
  // field positions, all fields sit at bit 0
  localparam int FLD_LSB = 0;
  // ==========================================
  // reset values
  localparam logic [NUM_CONTACT-1:0] RST_POL = 4'h0;
  localparam logic [FUNC_W-1:0] RST_FUNC = 16'h0000;
  localparam logic [FUNC_W-1:0] RST_FUNC_IN0 = 16'h2032;
  localparam logic [FUNC_W-1:0] RST_FUNC_IN2 = 16'h4201;
  localparam logic [DLY_W-1:0] RST_DLY = 16'h0000;
  localparam logic [MSG_W-1:0] RST_MSG = 8'h00;
  localparam logic [NUM_IN-1:0] RST_PIN_LEVEL = 8'h7f;
  // ==========================================
  // function codes, held as four bcd digits
  localparam logic [FUNC_W-1:0] FN_UNUSED = 16'h0000;
  localparam logic [FUNC_W-1:0] FN_BRK_CLOSE = 16'h1001;
  localparam logic [FUNC_W-1:0] FN_BRK_OPEN = 16'h1002;
  localparam logic [FUNC_W-1:0] FN_ALARM_RESET = 16'h2001;
  localparam logic [FUNC_W-1:0] FN_REMOTE_START = 16'h2032;
  localparam logic [FUNC_W-1:0] FN_MAN_START = 16'h2033;
  localparam logic [FUNC_W-1:0] FN_MAN_STOP = 16'h2034;
  localparam logic [FUNC_W-1:0] FN_MODE_OFF = 16'h2271;
  localparam logic [FUNC_W-1:0] FN_MODE_MAN = 16'h2272;
  localparam logic [FUNC_W-1:0] FN_MODE_AUTO = 16'h2273;
  localparam logic [FUNC_W-1:0] FN_SPEED_UP = 16'h2371;
  localparam logic [FUNC_W-1:0] FN_SPEED_DOWN = 16'h2372;
  localparam logic [FUNC_W-1:0] FN_SPEED_RESET = 16'h2373;
  localparam logic [FUNC_W-1:0] FN_PANEL_LOCK = 16'h2511;
  localparam logic [FUNC_W-1:0] FN_REMOTE_LOCK = 16'h2512;
  localparam logic [FUNC_W-1:0] FN_BRK_STATUS = 16'h3001;
  localparam logic [FUNC_W-1:0] FN_FUEL_START = 16'h3301;
  localparam logic [FUNC_W-1:0] FN_FUEL_STOP = 16'h3302;
  localparam logic [FUNC_W-1:0] FN_RED_START = 16'h3311;
  localparam logic [FUNC_W-1:0] FN_RED_STOP = 16'h3312;
  localparam logic [FUNC_W-1:0] FN_PRE_GEN = 16'h4001;
  localparam logic [FUNC_W-1:0] FN_DEACT_GEN = 16'h4003;
  localparam logic [FUNC_W-1:0] FN_SHUT_GEN = 16'h4004;
  localparam logic [FUNC_W-1:0] FN_PRE_OIL = 16'h4011;
  localparam logic [FUNC_W-1:0] FN_DEACT_OIL = 16'h4013;
  localparam logic [FUNC_W-1:0] FN_SHUT_OIL = 16'h4014;
  localparam logic [FUNC_W-1:0] FN_PRE_LOAD = 16'h4021;
  localparam logic [FUNC_W-1:0] FN_DEACT_LOAD = 16'h4023;
  localparam logic [FUNC_W-1:0] FN_SHUT_LOAD = 16'h4024;
  localparam logic [FUNC_W-1:0] FN_PRE_FUEL = 16'h4031;
  localparam logic [FUNC_W-1:0] FN_DEACT_FUEL = 16'h4033;
  localparam logic [FUNC_W-1:0] FN_SHUT_FUEL = 16'h4034;
  localparam logic [FUNC_W-1:0] FN_PRE_PUMP = 16'h4051;
  localparam logic [FUNC_W-1:0] FN_EMERG_STOP = 16'h4201;
  localparam logic [FUNC_W-1:0] FN_FUEL_LOW_SHUT = 16'h4211;
  localparam logic [FUNC_W-1:0] FN_FUEL_LOW_PRE = 16'h4212;
  localparam logic [FUNC_W-1:0] FN_FUEL_HIGH_PRE = 16'h4213;
  localparam logic [FUNC_W-1:0] FN_OIL_LOW_SHUT = 16'h4221;
  localparam logic [FUNC_W-1:0] FN_OIL_LOW_PRE = 16'h4222;
  localparam logic [FUNC_W-1:0] FN_COOL_HIGH_PRE = 16'h4231;
  localparam logic [FUNC_W-1:0] FN_COOL_HIGH_SHUT = 16'h4232;
  localparam logic [FUNC_W-1:0] FN_OVERLOAD = 16'h4241;
  localparam logic [FUNC_W-1:0] FN_OVERSPEED = 16'h4251;
  // ==========================================
  // which functions use the message setting
  function automatic logic fn_uses_msg(input logic [FUNC_W-1:0] code);
    case (code)
      FN_PRE_GEN, FN_DEACT_GEN, FN_SHUT_GEN, FN_PRE_OIL, FN_DEACT_OIL, FN_SHUT_OIL,
      FN_PRE_LOAD, FN_DEACT_LOAD, FN_SHUT_LOAD, FN_PRE_FUEL, FN_DEACT_FUEL, FN_SHUT_FUEL,
      FN_PRE_PUMP, FN_EMERG_STOP, FN_FUEL_LOW_SHUT, FN_FUEL_LOW_PRE, FN_FUEL_HIGH_PRE,
      FN_OIL_LOW_SHUT, FN_OIL_LOW_PRE, FN_COOL_HIGH_PRE, FN_COOL_HIGH_SHUT, FN_OVERLOAD,
      FN_OVERSPEED: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction
  // which functions use the delay setting
  function automatic logic fn_uses_delay(input logic [FUNC_W-1:0] code);
    return fn_uses_msg(code) || (code == FN_REMOTE_START) || (code == FN_BRK_STATUS);
  endfunction
endpackage

// ---- hdl/dic_sync.sv ----
// two-stage synchroniser for the input pin levels
// assumes asynchronous pins and one system clock
`timescale 1ns/1ns
module dic_sync
  import dic_pkg::*;
#(
  parameter int WIDTH = NUM_IN
) (
  input logic clk,
  input logic rst_n,
  input logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  // ==========================================
  // state
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
  } dic_sync_s;
  dic_sync_s r;
  dic_sync_s next_r;

  always_comb begin
    next_r.s1 = din;
    next_r.s2 = r.s1;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      r <= {WIDTH'(RST_PIN_LEVEL), WIDTH'(RST_PIN_LEVEL)};
    end else begin
      r <= next_r;
    end
  end

  assign dout = r.s2;
endmodule

// ---- hdl/dic_delay.sv ----
// activation delay timer for one conditioned input
// assumes a one-cycle tick per delay unit from the same clock
`timescale 1ns/1ns
module dic_delay
  import dic_pkg::*;
(
  input logic clk,
  input logic rst_n,
  input logic active,
  input logic useDelay,
  input logic tick,
  input logic [DLY_W-1:0] delay,
  output logic qual
);
  // ==========================================
  // state
  typedef struct packed {
    logic [DLY_W:0] cnt;
    logic qual;
  } dic_delay_s;
  dic_delay_s r;
  dic_delay_s next_r;
  logic done;

  // cnt above delay means a full delay of whole ticks has passed
  assign done = (delay == '0) || (r.cnt > {1'b0, delay});

  always_comb begin
    next_r = r;
    if (!active || !useDelay) begin
      next_r.cnt = '0; // see RULE_18
    end else if (tick && !done) begin
      next_r.cnt = r.cnt + (DLY_W+1)'(1);
    end
    next_r.qual = active && (!useDelay || done); // see RULE_18
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign qual = r.qual;

  // ==========================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  nodelay_follow_a: assert property (!useDelay && active |=> qual) // see RULE_06
    else $error("undelayed input not passed through");
  inactive_drop_a: assert property (!active |=> !qual && r.cnt == '0) // see RULE_18
    else $error("inactive input left qualified or timing not restarted");
  delay_full_a: assert property ($rose(qual) && $past(useDelay) && $past(delay) != '0
    |-> $past(r.cnt) > {1'b0, $past(delay)}) // see RULE_18
    else $error("input qualified before its delay ran out");
endmodule

// ---- hdl/dic_top.sv ----
// digital input conditioner: polarity, function select, delay and message
// assumes an APB master on clk and contact levels arriving asynchronously
//
// Functional notes
// RULE_01: tied low or alternator high means active
// RULE_02: one polarity bit per input inverts sense
// RULE_03: contacts in one word, others in second; here inputs 0-3 sit in polContact, contacts 4-6 and the alternator in polAux
// RULE_04: all polarity bits reset to zero
// RULE_05: each input holds function, delay, message
// RULE_06: delay and message only where function uses
// RULE_07: function zero drives nothing
// RULE_08: remote start, breaker status: delay only
// RULE_09: generic alarm codes: delay and message
// RULE_10: emergency stop: delay and message
// RULE_11: engine alarm codes: delay and message
// RULE_12: mode codes: off, manual, auto, undelayed
// RULE_13: speed codes: up, down, reset, undelayed
// RULE_14: breaker close and open requests, undelayed
// RULE_15: fuel and reductant pump levels, undelayed
// RULE_16: panel and remote locks while active
// RULE_17: alarm reset, manual start and stop
// RULE_18: delay needs continuous activity, restarts
//
// Our own choices: the register offsets and register access over APB.
`timescale 1ns/1ns
module dic_top
  import dic_pkg::*;
#(
  parameter int TICK_LEN = TICK_CYCLES
) (
  input logic clk,
  input logic rst_n,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [ADDR_W-1:0] paddr,
  input logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input logic [NUM_IN-2:0] contactLevel,
  input logic alternatorLevel,
  output logic modeOff,
  output logic modeMan,
  output logic modeAuto,
  output logic speedUp,
  output logic speedDown,
  output logic speedReset,
  output logic breakerClose,
  output logic breakerOpen,
  output logic fuelPumpStart,
  output logic fuelPumpStop,
  output logic reductantPumpStart,
  output logic reductantPumpStop,
  output logic panelLock,
  output logic remoteLock,
  output logic alarmReset,
  output logic manualStart,
  output logic manualStop,
  output logic remoteStart,
  output logic breakerStatus,
  output logic preAlarm,
  output logic deactivation,
  output logic shutdown,
  output logic emergencyStop,
  output logic fuelLowShutdown,
  output logic fuelLowPreAlarm,
  output logic fuelHighPreAlarm,
  output logic oilLowShutdown,
  output logic oilLowPreAlarm,
  output logic coolantHighPreAlarm,
  output logic coolantHighShutdown,
  output logic overload,
  output logic overspeed,
  output logic alarmMsgValid,
  output logic [MSG_W-1:0] alarmMsgIndex
);
  // ==========================================
  // state
  typedef struct packed {
    logic [NUM_CONTACT-1:0] polContact;
    logic [NUM_IN-NUM_CONTACT-1:0] polAux;
    logic [NUM_IN-1:0][FUNC_W-1:0] func;
    logic [NUM_IN-1:0][DLY_W-1:0] dly;
    logic [NUM_IN-1:0][MSG_W-1:0] msg;
    logic [31:0] tickCnt;
    logic tick;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [31:0] cmd;
    logic msgValid;
    logic [MSG_W-1:0] msgIndex;
  } dic_top_s;

  function automatic dic_top_s rst_value();
    dic_top_s v;
    v = '0;
    v.polContact = RST_POL; // see RULE_04
    v.polAux = RST_POL; // see RULE_04
    for (int i = 0; i < NUM_IN; i++) begin
      v.func[i] = RST_FUNC;
      v.dly[i] = RST_DLY;
      v.msg[i] = RST_MSG;
    end
    v.func[0] = RST_FUNC_IN0;
    v.func[2] = RST_FUNC_IN2;
    return v;
  endfunction
  localparam dic_top_s RST_STATE = rst_value();

  dic_top_s r;
  dic_top_s next_r;
  logic [NUM_IN-1:0] pinLevel;
  logic [NUM_IN-1:0] physActive;
  logic [NUM_IN-1:0] logicIn;
  logic [NUM_IN-1:0] useDelay;
  logic [NUM_IN-1:0] useMsg;
  logic [NUM_IN-1:0] qualVec;
  logic setupPh;
  logic writeAcc;

  // ==========================================
  // input conditioning
  dic_sync #(.WIDTH(NUM_IN)) uSync (
    .clk(clk),
    .rst_n(rst_n),
    .din({alternatorLevel, contactLevel}),
    .dout(pinLevel)
  );

  // contacts pull low when active, alternator sense drives high
  assign physActive = {pinLevel[NUM_IN-1], ~pinLevel[NUM_IN-2:0]}; // see RULE_01
  assign logicIn = physActive ^ {r.polAux, r.polContact}; // see RULE_02

  for (genvar gi = 0; gi < NUM_IN; gi++) begin : gInput
    assign useDelay[gi] = fn_uses_delay(r.func[gi]); // see RULE_06
    assign useMsg[gi] = fn_uses_msg(r.func[gi]); // see RULE_06
    dic_delay uDelay (
      .clk(clk),
      .rst_n(rst_n),
      .active(logicIn[gi]),
      .useDelay(useDelay[gi]),
      .tick(r.tick),
      .delay(r.dly[gi]),
      .qual(qualVec[gi])
    );
  end

  // any input whose function matches the code and is qualified
  function automatic logic hit(input logic [FUNC_W-1:0] code);
    logic h;
    h = 1'b0;
    if (code != FN_UNUSED) begin // see RULE_07
      for (int i = 0; i < NUM_IN; i++) begin
        h = h | ((r.func[i] == code) && qualVec[i]);
      end
    end
    return h;
  endfunction

  assign setupPh = psel && !penable;
  assign writeAcc = psel && penable && pwrite && r.pready && !r.pslverr;

  // ==========================================
  // next state
  always_comb begin
    next_r = r;
    // delay unit prescaler
    next_r.tick = (r.tickCnt == 32'(TICK_LEN - 1));
    next_r.tickCnt = next_r.tick ? '0 : r.tickCnt + 32'h1;
    // apb: decode in setup, answer in access
    next_r.pready = setupPh;
    next_r.pslverr = 1'b0;
    if (setupPh) begin
      next_r.prdata = '0;
      next_r.pslverr = 1'b1;
      if (paddr == OFS_POL_CONTACT) begin
        next_r.prdata[FLD_LSB +: NUM_CONTACT] = r.polContact; // see RULE_03
        next_r.pslverr = 1'b0;
      end
      if (paddr == OFS_POL_AUX) begin
        next_r.prdata[FLD_LSB +: NUM_IN-NUM_CONTACT] = r.polAux; // see RULE_03
        next_r.pslverr = 1'b0;
      end
      if (paddr == OFS_STATE) begin
        next_r.prdata[FLD_LSB +: NUM_IN] = logicIn;
        next_r.pslverr = 1'b0;
      end
      if (paddr == OFS_QUAL) begin
        next_r.prdata[FLD_LSB +: NUM_IN] = qualVec;
        next_r.pslverr = 1'b0;
      end
      for (int i = 0; i < NUM_IN; i++) begin
        if (paddr == OFS_FUNC_BASE + ADDR_W'(i * OFS_STRIDE)) begin
          next_r.prdata[FLD_LSB +: FUNC_W] = r.func[i];
          next_r.pslverr = 1'b0;
        end
        if (paddr == OFS_DLY_BASE + ADDR_W'(i * OFS_STRIDE)) begin
          next_r.prdata[FLD_LSB +: DLY_W] = r.dly[i];
          next_r.pslverr = 1'b0;
        end
        if (paddr == OFS_MSG_BASE + ADDR_W'(i * OFS_STRIDE)) begin
          next_r.prdata[FLD_LSB +: MSG_W] = r.msg[i];
          next_r.pslverr = 1'b0;
        end
      end
    end
    if (writeAcc) begin
      if (paddr == OFS_POL_CONTACT) begin
        next_r.polContact = pwdata[FLD_LSB +: NUM_CONTACT]; // see RULE_03
      end
      if (paddr == OFS_POL_AUX) begin
        next_r.polAux = pwdata[FLD_LSB +: NUM_IN-NUM_CONTACT]; // see RULE_03
      end
      for (int i = 0; i < NUM_IN; i++) begin
        if (paddr == OFS_FUNC_BASE + ADDR_W'(i * OFS_STRIDE)) begin
          next_r.func[i] = pwdata[FLD_LSB +: FUNC_W]; // see RULE_05
        end
        if (paddr == OFS_DLY_BASE + ADDR_W'(i * OFS_STRIDE)) begin
          next_r.dly[i] = pwdata[FLD_LSB +: DLY_W]; // see RULE_05
        end
        if (paddr == OFS_MSG_BASE + ADDR_W'(i * OFS_STRIDE)) begin
          next_r.msg[i] = pwdata[FLD_LSB +: MSG_W]; // see RULE_05
        end
      end
    end
    // function outputs
    next_r.cmd = '0;
    next_r.cmd[0] = hit(FN_MODE_OFF); // see RULE_12
    next_r.cmd[1] = hit(FN_MODE_MAN); // see RULE_12
    next_r.cmd[2] = hit(FN_MODE_AUTO); // see RULE_12
    next_r.cmd[3] = hit(FN_SPEED_UP); // see RULE_13
    next_r.cmd[4] = hit(FN_SPEED_DOWN); // see RULE_13
    next_r.cmd[5] = hit(FN_SPEED_RESET); // see RULE_13
    next_r.cmd[6] = hit(FN_BRK_CLOSE); // see RULE_14
    next_r.cmd[7] = hit(FN_BRK_OPEN); // see RULE_14
    next_r.cmd[8] = hit(FN_FUEL_START); // see RULE_15
    next_r.cmd[9] = hit(FN_FUEL_STOP); // see RULE_15
    next_r.cmd[10] = hit(FN_RED_START); // see RULE_15
    next_r.cmd[11] = hit(FN_RED_STOP); // see RULE_15
    next_r.cmd[12] = hit(FN_PANEL_LOCK); // see RULE_16
    next_r.cmd[13] = hit(FN_REMOTE_LOCK); // see RULE_16
    next_r.cmd[14] = hit(FN_ALARM_RESET); // see RULE_17
    next_r.cmd[15] = hit(FN_MAN_START); // see RULE_17
    next_r.cmd[16] = hit(FN_MAN_STOP); // see RULE_17
    next_r.cmd[17] = hit(FN_REMOTE_START); // see RULE_08
    next_r.cmd[18] = hit(FN_BRK_STATUS); // see RULE_08
    next_r.cmd[19] = hit(FN_PRE_GEN) | hit(FN_PRE_OIL) | hit(FN_PRE_LOAD) | hit(FN_PRE_FUEL)
      | hit(FN_PRE_PUMP); // see RULE_09
    next_r.cmd[20] = hit(FN_DEACT_GEN) | hit(FN_DEACT_OIL) | hit(FN_DEACT_LOAD)
      | hit(FN_DEACT_FUEL); // see RULE_09
    next_r.cmd[21] = hit(FN_SHUT_GEN) | hit(FN_SHUT_OIL) | hit(FN_SHUT_LOAD) | hit(FN_SHUT_FUEL); // see RULE_09
    next_r.cmd[22] = hit(FN_EMERG_STOP); // see RULE_10
    next_r.cmd[23] = hit(FN_FUEL_LOW_SHUT); // see RULE_11
    next_r.cmd[24] = hit(FN_FUEL_LOW_PRE); // see RULE_11
    next_r.cmd[25] = hit(FN_FUEL_HIGH_PRE); // see RULE_11
    next_r.cmd[26] = hit(FN_OIL_LOW_SHUT); // see RULE_11
    next_r.cmd[27] = hit(FN_OIL_LOW_PRE); // see RULE_11
    next_r.cmd[28] = hit(FN_COOL_HIGH_PRE); // see RULE_11
    next_r.cmd[29] = hit(FN_COOL_HIGH_SHUT); // see RULE_11
    next_r.cmd[30] = hit(FN_OVERLOAD); // see RULE_11
    next_r.cmd[31] = hit(FN_OVERSPEED); // see RULE_11
    // message of the lowest qualified input that uses one
    next_r.msgValid = 1'b0;
    next_r.msgIndex = '0;
    for (int i = NUM_IN - 1; i >= 0; i--) begin
      if (useMsg[i] && qualVec[i]) begin
        next_r.msgValid = 1'b1; // see RULE_06
        next_r.msgIndex = r.msg[i]; // see RULE_10
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      r <= RST_STATE;
    end else begin
      r <= next_r;
    end
  end

  // ==========================================
  // outputs
  assign prdata = r.prdata;
  assign pready = r.pready;
  assign pslverr = r.pslverr;
  assign {overspeed, overload, coolantHighShutdown, coolantHighPreAlarm, oilLowPreAlarm, oilLowShutdown,
    fuelHighPreAlarm, fuelLowPreAlarm, fuelLowShutdown, emergencyStop, shutdown, deactivation, preAlarm,
    breakerStatus, remoteStart, manualStop, manualStart, alarmReset, remoteLock, panelLock,
    reductantPumpStop, reductantPumpStart, fuelPumpStop, fuelPumpStart, breakerOpen, breakerClose,
    speedReset, speedDown, speedUp, modeAuto, modeMan, modeOff} = r.cmd;
  assign alarmMsgValid = r.msgValid;
  assign alarmMsgIndex = r.msgIndex;

  // ==========================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence apbSetup;
    psel && !penable;
  endsequence
  sequence polWrite;
    psel && penable && pwrite && pready && paddr == OFS_POL_CONTACT;
  endsequence

  apb_answer_a: assert property (apbSetup |=> pready)
    else $error("apb access not answered in one cycle");
  pol_write_a: assert property (polWrite |=> r.polContact == $past(pwdata[NUM_CONTACT-1:0])) // see RULE_03
    else $error("contact polarity write lost");
  pol_reset_a: assert property ($rose(rst_n) |-> r.polContact == '0 && r.polAux == '0) // see RULE_04
    else $error("polarity not cleared by reset");
  sense_map_a: assert property (logicIn[NUM_IN-1] == (pinLevel[NUM_IN-1] ^ r.polAux[NUM_IN-NUM_CONTACT-1])) // see RULE_02
    else $error("alternator sense polarity wrong");
  unused_quiet_a: assert property ((r.func == '0) [*3] |-> r.cmd == '0) // see RULE_07
    else $error("unused inputs drive a function");
  msg_gate_a: assert property ((useMsg == '0) [*2] |=> !alarmMsgValid) // see RULE_06
    else $error("message shown for a function without one");
  mode_off_a: assert property ((r.func[1] == FN_MODE_OFF && logicIn[1]) [*3] |=> modeOff) // see RULE_12
    else $error("mode off request not raised");
  speed_up_a: assert property ((r.func[1] == FN_SPEED_UP && logicIn[1]) [*3] |=> speedUp) // see RULE_13
    else $error("speed increase not raised");
  brk_close_a: assert property ((r.func[1] == FN_BRK_CLOSE && logicIn[1]) [*3] |=> breakerClose) // see RULE_14
    else $error("breaker close request not raised");
  panel_lock_a: assert property ((r.func[1] == FN_PANEL_LOCK && logicIn[1]) [*3] |=> panelLock) // see RULE_16
    else $error("panel lock not held");
  estop_cause_a: assert property ($rose(emergencyStop) |-> $past(qualVec) != '0) // see RULE_10
    else $error("emergency stop without a qualified input");
endmodule

// ---- dv/dic_contacts.sv ----
// field contact model: switches and the alternator sense source
// assumes pull-ups on contact pins and a pull-down on the sense pin
`timescale 1ns/1ns
module dic_contacts (
  input wire logic [7:0] closed,
  output logic [6:0] contactLevel,
  output logic alternatorLevel
);
  // ==========================================
  // pin levels
  // closed pulls to negative, open floats high
  assign contactLevel = ~closed[6:0];
  // voltage present when closed, else pulled low
  assign alternatorLevel = closed[7];
endmodule

// ---- dv/test_digital_input_conditioner.sv ----
// bench for the digital input conditioner
// assumes the contact model drives the pins; APB is driven here
`timescale 1ns/1ns
module test_digital_input_conditioner;
  import dic_pkg::*;
  localparam int TL = 4;
  logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd, m;
  wire [31:0] f;
  logic pready, pslverr, err, alternatorLevel, msgValid;
  logic [7:0] closed = '0;
  logic [6:0] contactLevel;
  logic [MSG_W-1:0] msgIndex;
  int errors = 0, check_count = 0, cycles = 0, d;
  logic [15:0] codes [32] = '{16'h2271, 16'h2272, 16'h2273, 16'h2371, 16'h2372, 16'h2373, 16'h1001,
    16'h1002, 16'h3301, 16'h3302, 16'h3311, 16'h3312, 16'h2511, 16'h2512, 16'h2001, 16'h2033, 16'h2034,
    16'h2032, 16'h3001, 16'h4001, 16'h4003, 16'h4004, 16'h4201, 16'h4211, 16'h4212, 16'h4213, 16'h4221,
    16'h4222, 16'h4231, 16'h4232, 16'h4241, 16'h4251};
  always #2 clk = ~clk;
  dic_contacts i_dic_contacts (.closed(closed), .contactLevel(contactLevel), .alternatorLevel(alternatorLevel));
  dic_top #(.TICK_LEN(TL)) i_dic_top (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .contactLevel(contactLevel), .alternatorLevel(alternatorLevel), .modeOff(f[0]), .modeMan(f[1]),
    .modeAuto(f[2]), .speedUp(f[3]), .speedDown(f[4]), .speedReset(f[5]), .breakerClose(f[6]),
    .breakerOpen(f[7]), .fuelPumpStart(f[8]), .fuelPumpStop(f[9]), .reductantPumpStart(f[10]),
    .reductantPumpStop(f[11]), .panelLock(f[12]), .remoteLock(f[13]), .alarmReset(f[14]),
    .manualStart(f[15]), .manualStop(f[16]), .remoteStart(f[17]), .breakerStatus(f[18]),
    .preAlarm(f[19]), .deactivation(f[20]), .shutdown(f[21]), .emergencyStop(f[22]),
    .fuelLowShutdown(f[23]), .fuelLowPreAlarm(f[24]), .fuelHighPreAlarm(f[25]), .oilLowShutdown(f[26]),
    .oilLowPreAlarm(f[27]), .coolantHighPreAlarm(f[28]), .coolantHighShutdown(f[29]), .overload(f[30]),
    .overspeed(f[31]), .alarmMsgValid(msgValid), .alarmMsgIndex(msgIndex));
  // ==========================================
  // shared tasks
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] dt);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= dt;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) begin
      @(posedge clk);
      n++;
    end
    rd = prdata;
    err = pslverr;
    chk("apbWait", 0, n);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic complete_run();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 8000) begin
      errors++;
      complete_run();
    end
  end
  // ==========================================
  // main sequence
  initial begin
    void'($urandom(33944));
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    apb(0, OFS_POL_CONTACT, 0);
    chk("polContact", 0, rd);
    apb(0, OFS_POL_AUX, 0);
    chk("polAux", 0, rd);
    apb(0, OFS_FUNC_BASE + 12'h008, 0);
    chk("func2", 32'h4201, rd);
    apb(0, 12'h0fc, 0);
    chk("unmapped", 1, err);
    m = $urandom;
    apb(1, OFS_MSG_BASE + 12'h010, m);
    apb(0, OFS_MSG_BASE + 12'h010, 0);
    chk("msgReg", {24'h0, m[7:0]}, rd);
    $display("test reset and registers done");
    apb(1, OFS_MSG_BASE + 12'h004, m);
    foreach (codes[i]) begin
      apb(1, OFS_FUNC_BASE + 12'h004, {16'h0, codes[i]});
      closed[1] <= 1'b1;
      repeat (6) @(negedge clk);
      chk("fnOut", 32'h1 << i, f);
      chk("msgIndex", (i > 18) ? {24'h0, m[7:0]} : 0, {24'h0, msgIndex});
      @(posedge clk);
      closed[1] <= 1'b0;
      repeat (6) @(negedge clk);
      chk("fnOff", 0, f);
    end
    apb(1, OFS_FUNC_BASE + 12'h004, 0);
    apb(1, OFS_FUNC_BASE, 0);
    apb(1, OFS_FUNC_BASE + 12'h008, 0);
    closed[1] <= 1'b1;
    repeat (6) @(negedge clk);
    chk("unused", 0, {f[30:0], msgValid});
    $display("test function codes done");
    apb(1, OFS_DLY_BASE + 12'h004, 32'hffff);
    apb(1, OFS_FUNC_BASE + 12'h004, 32'h2271);
    apb(1, OFS_FUNC_BASE + 12'h01c, 32'h2272);
    apb(1, OFS_POL_CONTACT, 32'h2);
    closed <= 8'h00;
    apb(1, OFS_POL_AUX, 32'h8);
    repeat (6) @(negedge clk);
    chk("inverted", 32'h3, f);
    @(posedge clk);
    closed <= 8'h82;
    repeat (6) @(negedge clk);
    chk("invertedClosed", 0, f);
    apb(1, OFS_POL_AUX, 0);
    repeat (6) @(negedge clk);
    chk("alternator", 32'h2, f);
    apb(1, OFS_POL_CONTACT, 0);
    closed <= 8'h00;
    $display("test polarity done");
    d = 1 + $urandom % 4;
    apb(1, OFS_FUNC_BASE + 12'h00c, 32'h4011);
    apb(1, OFS_DLY_BASE + 12'h00c, d);
    apb(1, OFS_MSG_BASE + 12'h00c, m ^ 32'h5a);
    closed[3] <= 1'b1;
    repeat (d * TL) @(posedge clk);
    closed[3] <= 1'b0;
    repeat (2) @(posedge clk);
    closed[3] <= 1'b1;
    repeat (d * TL) @(negedge clk);
    chk("restarted", 0, f);
    repeat (TL + 6) @(negedge clk);
    chk("delayed", 32'h80000, f);
    chk("delayedMsg", {24'h0, m[7:0] ^ 8'h5a}, {24'h0, msgIndex});
    $display("test delay done");
    complete_run();
  end
endmodule
